// [psc_pkg.sv]
// constants, types and register map for the pci slave special cycle block
`default_nettype none
package psc_pkg;
    localparam logic [11:0] OFF_IMG3_CTL   = 12'h13C;
    localparam logic [11:0] OFF_IMG3_BASE  = 12'h140;
    localparam logic [11:0] OFF_IMG3_BOUND = 12'h144;
    localparam logic [11:0] OFF_IMG3_TO    = 12'h148;
    localparam logic [11:0] OFF_SC_CTL     = 12'h170;
    localparam logic [11:0] OFF_SC_ADDR    = 12'h174;
    localparam logic [11:0] OFF_SC_MASK    = 12'h178;
    localparam logic [11:0] OFF_SC_CMP     = 12'h17C;
    localparam logic [11:0] OFF_SC_SWP     = 12'h180;
    localparam logic [11:0] OFF_MISC       = 12'h184;
    localparam logic [11:0] OFF_STATUS     = 12'h1FC;

    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam logic [31:0] IMG3_CTL_MASK  = 32'hC000_0001;
    localparam logic [31:0] TOP16_MASK     = 32'hFFFF_0000;
    localparam logic [31:0] SC_CTL_MASK    = 32'h0000_0007;
    localparam logic [31:0] SC_ADDR_MASK   = 32'hFFFF_FFFC;
    localparam logic [31:0] MISC_MASK      = 32'hF700_0000;

    localparam int IMG_EN_BIT   = 31;
    localparam int IMG_POSTED_WRITE_ENABLE_BIT = 30;
    localparam int IMG_LAS_BIT  = 0;
    localparam int SC_LAS_BIT   = 2;
    localparam int CWT_LSB      = 24;

    localparam logic [1:0] SEL_DISABLED = 2'h0;
    localparam logic [1:0] SEL_RMW      = 2'h1;
    localparam logic [1:0] SEL_ADDR     = 2'h2;

    // window lengths in pci clocks: code n from 1 to 6 holds CWT_BASE_CLOCKS << (n-1), codes 0 and 7 release
    localparam logic [9:0] CWT_BASE_CLOCKS = 10'h010;
    localparam logic [2:0] CWT_RELEASE     = 3'h0;
    localparam logic [2:0] CWT_MAX_CODE    = 3'h6;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ORD, ST_ADO, ST_RMW_RD, ST_RMW_WR, ST_DONE
    } psc_state_e;

    typedef enum logic [1:0] {
        VME_ORDINARY, VME_ADDR_ONLY, VME_RMW_READ, VME_RMW_WRITE
    } psc_vme_kind_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        io;
        logic [31:0] addr;
        logic [31:0] wdata;
    } psc_access_s;

    typedef struct packed {
        logic          req;
        psc_vme_kind_e kind;
        logic          lock;
        logic          write;
        logic [31:0]   addr;
        logic [31:0]   wdata;
    } psc_vme_req_s;
endpackage : psc_pkg
`default_nettype wire

// [psc_slave.sv]
// pci slave channel: image 3 translation, special cycle generator, coupled window timer
// Function
// - vme address high half is pci plus offset
// - matching special address makes address-only or rmw
// - rmw starts on read only, never write
// - address-only starts on read or write
// - select field: off, rmw, address-only, reserved
// - space bit matches memory or io, rmw only
// - match compares address bits 31 to 2
// - no 64-bit acknowledge on special match
// - mask picks bits for compare and swap
// - read data compared under mask
// - on match write swap bits under mask
// - legacy retry field stored, no effect
// - window code: release, or 16 to 512
// - hold vme bus for window after coupled
// - each coupled transaction restarts full window
// - window expiry releases the vme bus
// - image decodes base up to bound, zero unbounded
// - io image ignores posted write, always coupled
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module psc_slave (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic [11:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [31:0]           reg_rdata,
    input  wire logic                  pci_clk,
    input  wire psc_pkg::psc_access_s  acc,
    output logic                       acc_done,
    output logic                       acc_claimed,
    output logic      [31:0]           acc_rdata,
    output logic                       ack64_permit,
    output psc_pkg::psc_vme_req_s      vme,
    input  wire logic                  vme_ack,
    input  wire logic [31:0]           vme_rdata,
    output logic                       vme_own
);
    import psc_pkg::*;

    logic [31:0] img3_ctl, img3_base, img3_bound, img3_to;
    logic [31:0] sc_ctl, sc_addr, sc_mask, sc_cmp, sc_swp, misc;
    logic [31:0] next_img3_ctl, next_img3_base, next_img3_bound, next_img3_to;
    logic [31:0] next_sc_ctl, next_sc_addr, next_sc_mask, next_sc_cmp, next_sc_swp, next_misc;
    logic [31:0] next_reg_rdata;

    psc_state_e   state, next_state;
    psc_access_s  cur, next_cur;
    psc_vme_req_s next_vme;
    logic         coupled, next_coupled;
    logic         cmp_ok, next_cmp_ok;
    logic         next_acc_done, next_acc_claimed;
    logic [31:0]  next_acc_rdata;
    logic [9:0]   win_cnt, next_win_cnt;

    // pci clock is sampled: two stages, then edge detect on the settled copy
    logic pci_clk_s1, pci_clk_s2, pci_clk_s3;
    logic pci_tick;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pci_clk_s1 <= 1'b0;
            pci_clk_s2 <= 1'b0;
            pci_clk_s3 <= 1'b0;
        end else begin
            pci_clk_s1 <= pci_clk;
            pci_clk_s2 <= pci_clk_s1;
            pci_clk_s3 <= pci_clk_s2;
        end
    end
    assign pci_tick = pci_clk_s2 & ~pci_clk_s3;

    // register file
    always_comb begin
        next_img3_ctl   = img3_ctl;
        next_img3_base  = img3_base;
        next_img3_bound = img3_bound;
        next_img3_to    = img3_to;
        next_sc_ctl     = sc_ctl;
        next_sc_addr    = sc_addr;
        next_sc_mask    = sc_mask;
        next_sc_cmp     = sc_cmp;
        next_sc_swp     = sc_swp;
        next_misc       = misc;
        next_reg_rdata  = REG_RESET;
        if (reg_write) begin
            case (reg_addr)
                OFF_IMG3_CTL:   next_img3_ctl   = reg_wdata & IMG3_CTL_MASK;
                OFF_IMG3_BASE:  next_img3_base  = reg_wdata & TOP16_MASK;
                OFF_IMG3_BOUND: next_img3_bound = reg_wdata & TOP16_MASK;
                OFF_IMG3_TO:    next_img3_to    = reg_wdata & TOP16_MASK;
                OFF_SC_CTL:     next_sc_ctl     = reg_wdata & SC_CTL_MASK;
                OFF_SC_ADDR:    next_sc_addr    = reg_wdata & SC_ADDR_MASK;
                OFF_SC_MASK:    next_sc_mask    = reg_wdata;
                OFF_SC_CMP:     next_sc_cmp     = reg_wdata;
                OFF_SC_SWP:     next_sc_swp     = reg_wdata;
                // legacy retry bits are kept for readback only
                OFF_MISC:       next_misc       = reg_wdata & MISC_MASK;
                default:        next_misc       = misc;
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                OFF_IMG3_CTL:   next_reg_rdata = img3_ctl;
                OFF_IMG3_BASE:  next_reg_rdata = img3_base;
                OFF_IMG3_BOUND: next_reg_rdata = img3_bound;
                OFF_IMG3_TO:    next_reg_rdata = img3_to;
                OFF_SC_CTL:     next_reg_rdata = sc_ctl;
                OFF_SC_ADDR:    next_reg_rdata = sc_addr;
                OFF_SC_MASK:    next_reg_rdata = sc_mask;
                OFF_SC_CMP:     next_reg_rdata = sc_cmp;
                OFF_SC_SWP:     next_reg_rdata = sc_swp;
                OFF_MISC:       next_reg_rdata = misc;
                OFF_STATUS:     next_reg_rdata = {29'h0, cmp_ok, vme_own, state != ST_IDLE};
                default:        next_reg_rdata = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            img3_ctl   <= REG_RESET;
            img3_base  <= REG_RESET;
            img3_bound <= REG_RESET;
            img3_to    <= REG_RESET;
            sc_ctl     <= REG_RESET;
            sc_addr    <= REG_RESET;
            sc_mask    <= REG_RESET;
            sc_cmp     <= REG_RESET;
            sc_swp     <= REG_RESET;
            misc       <= REG_RESET;
            reg_rdata  <= REG_RESET;
        end else begin
            img3_ctl   <= next_img3_ctl;
            img3_base  <= next_img3_base;
            img3_bound <= next_img3_bound;
            img3_to    <= next_img3_to;
            sc_ctl     <= next_sc_ctl;
            sc_addr    <= next_sc_addr;
            sc_mask    <= next_sc_mask;
            sc_cmp     <= next_sc_cmp;
            sc_swp     <= next_sc_swp;
            misc       <= next_misc;
            reg_rdata  <= next_reg_rdata;
        end
    end

    // decode of the incoming access
    logic [1:0]  sc_sel;
    logic [2:0]  coupled_window_timer;
    logic        addr_eq, rmw_hit, ado_hit, start_rmw, img3_hit, posted;
    logic [31:0] xlat_addr, rmw_merge;
    logic [9:0]  win_load;

    assign sc_sel    = sc_ctl[1:0];
    assign coupled_window_timer       = misc[CWT_LSB +: 3];
    assign addr_eq   = acc.addr[31:2] == sc_addr[31:2];
    // reserved select 11 matches neither kind and falls to the image
    assign rmw_hit   = (sc_sel == SEL_RMW) && addr_eq && (acc.io == sc_ctl[SC_LAS_BIT]);
    assign ado_hit   = (sc_sel == SEL_ADDR) && addr_eq;
    assign start_rmw = rmw_hit && !acc.write;
    assign ack64_permit = !(addr_eq && ((sc_sel == SEL_RMW) || (sc_sel == SEL_ADDR)));
    assign img3_hit  = img3_ctl[IMG_EN_BIT] && (acc.io == img3_ctl[IMG_LAS_BIT])
                     && (acc.addr[31:16] >= img3_base[31:16])
                     && ((img3_bound[31:16] == 16'h0000) || (acc.addr[31:16] < img3_bound[31:16]));
    // io images are always coupled whatever the posted write bit says
    assign posted    = acc.write && img3_ctl[IMG_POSTED_WRITE_ENABLE_BIT] && !img3_ctl[IMG_LAS_BIT];
    assign xlat_addr = {16'(acc.addr[31:16] + img3_to[31:16]), acc.addr[15:0]};
    assign rmw_merge = (vme_rdata & ~sc_mask) | (sc_swp & sc_mask);
    assign win_load  = ((coupled_window_timer == CWT_RELEASE) || (coupled_window_timer > CWT_MAX_CODE)) ? 10'h000
                     : 10'(CWT_BASE_CLOCKS << (coupled_window_timer - 3'h1));

    // transaction sequencer and coupled window
    always_comb begin
        next_state       = state;
        next_cur         = cur;
        next_vme         = vme;
        next_coupled     = coupled;
        next_cmp_ok      = cmp_ok;
        next_acc_done    = 1'b0;
        next_acc_claimed = 1'b0;
        next_acc_rdata   = acc_rdata;
        next_win_cnt     = win_cnt;
        if (pci_tick && (win_cnt != 10'h000))
            next_win_cnt = win_cnt - 10'h001;
        case (state)
            ST_IDLE: begin
                if (acc.valid) begin
                    next_cur = acc;
                    next_cmp_ok = 1'b0;
                    if (start_rmw) begin
                        next_state   = ST_RMW_RD;
                        next_vme     = '{1'b1, VME_RMW_READ, 1'b1, 1'b0, xlat_addr, 32'h0000_0000};
                        next_coupled = 1'b1;
                    end else if (ado_hit) begin
                        next_state   = ST_ADO;
                        next_vme     = '{1'b1, VME_ADDR_ONLY, 1'b0, acc.write, xlat_addr, 32'h0000_0000};
                        next_coupled = 1'b1;
                    end else if (img3_hit) begin
                        next_state   = ST_ORD;
                        next_vme     = '{1'b1, VME_ORDINARY, 1'b0, acc.write, xlat_addr, acc.wdata};
                        next_coupled = !posted;
                    end else begin
                        // nobody claims it: answer at once so the front end can abort
                        next_acc_done  = 1'b1;
                        next_acc_rdata = 32'h0000_0000;
                    end
                end
            end
            ST_ORD, ST_ADO: begin
                if (vme_ack) begin
                    next_vme.req   = 1'b0;
                    next_acc_rdata = ((state == ST_ORD) && !cur.write) ? vme_rdata : 32'h0000_0000;
                    next_state     = ST_DONE;
                end
            end
            ST_RMW_RD: begin
                if (vme_ack) begin
                    next_acc_rdata = vme_rdata;
                    next_cmp_ok    = ((vme_rdata ^ sc_cmp) & sc_mask) == 32'h0000_0000;
                    if (((vme_rdata ^ sc_cmp) & sc_mask) == 32'h0000_0000) begin
                        next_vme   = '{1'b1, VME_RMW_WRITE, 1'b1, 1'b1, vme.addr, rmw_merge};
                        next_state = ST_RMW_WR;
                    end else begin
                        next_vme.req  = 1'b0;
                        next_vme.lock = 1'b0;
                        next_state    = ST_DONE;
                    end
                end
            end
            ST_RMW_WR: begin
                if (vme_ack) begin
                    next_vme.req  = 1'b0;
                    next_vme.lock = 1'b0;
                    next_state    = ST_DONE;
                end
            end
            ST_DONE: begin
                next_acc_done    = 1'b1;
                next_acc_claimed = 1'b1;
                next_state       = ST_IDLE;
                // restart from full count, a later tick only counts down after this
                if (coupled)
                    next_win_cnt = win_load;
            end
            default: begin
                next_state = ST_IDLE;
                next_vme   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state       <= ST_IDLE;
            cur         <= '0;
            vme         <= '0;
            coupled     <= 1'b0;
            cmp_ok      <= 1'b0;
            acc_done    <= 1'b0;
            acc_claimed <= 1'b0;
            acc_rdata   <= 32'h0000_0000;
            win_cnt     <= 10'h000;
        end else begin
            state       <= next_state;
            cur         <= next_cur;
            vme         <= next_vme;
            coupled     <= next_coupled;
            cmp_ok      <= next_cmp_ok;
            acc_done    <= next_acc_done;
            acc_claimed <= next_acc_claimed;
            acc_rdata   <= next_acc_rdata;
            win_cnt     <= next_win_cnt;
        end
    end

    assign vme_own = (state != ST_IDLE) || (win_cnt != 10'h000);

    property p_translate;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && img3_hit && !rmw_hit && !ado_hit)
            |=> vme.addr[31:16] == 16'($past(acc.addr[31:16]) + img3_to[31:16]);
    endproperty
    a_translate: assert property (p_translate) else $error("image 3 address not translated");

    property p_rmw_write_ignored;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && acc.write) |=> state != ST_RMW_RD;
    endproperty
    a_rmw_write_ignored: assert property (p_rmw_write_ignored) else $error("write started rmw");

    property p_ado_start;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && ado_hit)
            |=> state == ST_ADO && vme.req && vme.kind == VME_ADDR_ONLY;
    endproperty
    a_ado_start: assert property (p_ado_start) else $error("address-only cycle not started");

    property p_rmw_space;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && acc.io != sc_ctl[SC_LAS_BIT]) |=> state != ST_RMW_RD;
    endproperty
    a_rmw_space: assert property (p_rmw_space) else $error("rmw in wrong pci space");

    property p_no_ack64;
        @(posedge sys_clk) disable iff (reset)
        (rmw_hit || ado_hit) |-> !ack64_permit;
    endproperty
    a_no_ack64: assert property (p_no_ack64) else $error("64-bit acknowledge on special match");

    property p_swap;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_RMW_RD && vme_ack && (((vme_rdata ^ sc_cmp) & sc_mask) == 32'h0000_0000))
            |=> state == ST_RMW_WR && vme.write && vme.lock
                && vme.wdata == (($past(vme_rdata) & ~sc_mask) | (sc_swp & sc_mask));
    endproperty
    a_swap: assert property (p_swap) else $error("swap data wrong");

    property p_miss;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_RMW_RD && vme_ack && (((vme_rdata ^ sc_cmp) & sc_mask) != 32'h0000_0000))
            |=> state == ST_DONE && !vme.req ##1 acc_done;
    endproperty
    a_miss: assert property (p_miss) else $error("write-back after compare miss");

    property p_window_load;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_DONE && coupled && coupled_window_timer == 3'h1) |=> win_cnt == 10'h010 && vme_own;
    endproperty
    a_window_load: assert property (p_window_load) else $error("window not loaded to 16");

    property p_release;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && !acc.valid && win_cnt == 10'h001 && pci_tick) |=> !vme_own;
    endproperty
    a_release: assert property (p_release) else $error("bus kept after window expiry");

    property p_disabled;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && sc_sel == SEL_DISABLED && img3_hit)
            |=> state == ST_ORD && vme.kind == VME_ORDINARY;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled select made special cycle");

    property p_unclaimed;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && !start_rmw && !ado_hit && !img3_hit)
            |=> acc_done && !acc_claimed && !vme.req;
    endproperty
    a_unclaimed: assert property (p_unclaimed) else $error("access outside image was claimed");

    property p_io_coupled;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && acc.valid && !start_rmw && !ado_hit && img3_hit && img3_ctl[IMG_LAS_BIT])
            |=> coupled;
    endproperty
    a_io_coupled: assert property (p_io_coupled) else $error("io image access posted");

    // the window may only shrink on a pci tick
    property p_window_hold;
        @(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && !acc.valid && !pci_tick) |=> win_cnt == $past(win_cnt);
    endproperty
    a_window_hold: assert property (p_window_hold) else $error("window count moved without a tick");

    c_rmw_swap:  cover property (@(posedge sys_clk) disable iff (reset) state == ST_RMW_WR && vme_ack);
    c_rmw_miss:  cover property (@(posedge sys_clk) disable iff (reset) state == ST_RMW_RD && vme_ack && !next_cmp_ok);
    c_ado:       cover property (@(posedge sys_clk) disable iff (reset) state == ST_ADO && vme_ack);
    c_win_ended: cover property (@(posedge sys_clk) disable iff (reset) win_cnt == 10'h001 ##1 win_cnt == 10'h000);
    c_posted:    cover property (@(posedge sys_clk) disable iff (reset) state == ST_ORD && vme_ack && !coupled);
endmodule : psc_slave
`default_nettype wire

// [psc_slave_bench.sv]
// self-checking bench for the pci slave special cycle block
`timescale 1ns/1ns
`default_nettype none
module psc_slave_bench;
    import psc_pkg::*;
    localparam logic [31:0] SPC = 32'h2345_6788;
    logic         sys_clk = 1'b0;
    logic         reset = 1'b1;
    logic         pci_clk = 1'b0;
    logic [11:0]  reg_addr = 12'h000;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_write = 1'b0;
    logic         reg_read = 1'b0;
    logic         slow = 1'b0;
    logic         load = 1'b0;
    logic [31:0]  load_data = 32'h0;
    psc_access_s  acc = '0;
    logic [31:0]  reg_rdata, acc_rdata, vme_rdata, mem, seen_addr;
    logic         acc_done, acc_claimed, ack64_permit, vme_ack, vme_own;
    logic [3:0]   kinds;
    psc_vme_req_s vme;
    int           err_count = 0;
    int           samples_checked = 0;

    always #2 sys_clk = ~sys_clk;
    // offset so link edges never coincide with ours
    initial begin
        #1;
        forever #24 pci_clk = ~pci_clk;
    end

    psc_slave u_psc_slave (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pci_clk(pci_clk), .acc(acc),
        .acc_done(acc_done), .acc_claimed(acc_claimed), .acc_rdata(acc_rdata), .ack64_permit(ack64_permit),
        .vme(vme), .vme_ack(vme_ack), .vme_rdata(vme_rdata), .vme_own(vme_own));
    psc_vme_model u_psc_vme_model (.sys_clk(sys_clk), .reset(reset), .slow(slow), .load(load),
        .load_data(load_data), .vme(vme), .vme_ack(vme_ack), .vme_rdata(vme_rdata), .mem(mem));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(posedge sys_clk);
        check("reg_rdata", reg_rdata, exp);
    endtask : reg_rd

    task automatic preload(input logic [31:0] d);
        @(posedge sys_clk);
        load      <= 1'b1;
        load_data <= d;
        @(posedge sys_clk);
        load <= 1'b0;
    endtask : preload

    // one pci access; records the vme phase kinds acknowledged on the way
    task automatic do_acc(input logic w, input logic io, input logic [31:0] a, input logic [31:0] wd);
        int i;
        kinds = 4'h0;
        @(posedge sys_clk);
        acc <= '{1'b1, w, io, a, wd};
        @(posedge sys_clk);
        acc.valid <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(posedge sys_clk);
            if (vme.req === 1'b1 && vme_ack === 1'b1) begin
                kinds[vme.kind] = 1'b1;
                seen_addr = vme.addr;
            end
            if (acc_done === 1'b1) break;
        end
        if (i == 300) begin
            check("acc_done timeout", 1'b0, 1'b1);
            end_of_test();
        end
    endtask : do_acc

    task automatic own_time(output int n);
        for (n = 0; n < 7000 && vme_own === 1'b1; n++) @(posedge sys_clk);
        if (n == 7000) begin
            check("vme_own timeout", 1'b0, 1'b1);
            end_of_test();
        end
    endtask : own_time

    task automatic test_regs;
        logic [11:0] offs [8] = '{OFF_IMG3_TO, OFF_SC_CTL, OFF_SC_ADDR, OFF_SC_MASK, OFF_SC_CMP, OFF_SC_SWP,
            OFF_MISC, 12'h100};
        logic [31:0] msk [8] = '{TOP16_MASK, SC_CTL_MASK, SC_ADDR_MASK, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
            32'hFFFF_FFFF, MISC_MASK, 32'h0};
        for (int i = 0; i < 8; i++) begin
            reg_rd(offs[i], REG_RESET);
            reg_wr(offs[i], 32'hFFFF_FFFF);
            reg_rd(offs[i], msk[i]);
            reg_wr(offs[i], 32'h0);
        end
    endtask : test_regs

    task automatic test_translate;
        reg_wr(OFF_IMG3_CTL, 32'h8000_0000);
        reg_wr(OFF_IMG3_BASE, 32'h1000_0000);
        reg_wr(OFF_IMG3_TO, 32'hF000_0000);
        reg_wr(OFF_SC_ADDR, SPC);
        preload(32'hCAFE_0001);
        do_acc(1'b0, 1'b0, SPC, 32'h0);
        check("vme.addr", seen_addr, 32'h1345_6788);
        check("kinds", kinds, 4'h1);
        check("acc_rdata", acc_rdata, 32'hCAFE_0001);
        check("acc_claimed", acc_claimed, 1'b1);
        check("ack64_permit", ack64_permit, 1'b1);
        do_acc(1'b0, 1'b0, 32'h0FFF_FFFC, 32'h0);
        check("acc_claimed", acc_claimed, 1'b0);
        reg_wr(OFF_IMG3_BOUND, 32'h3000_0000);
        do_acc(1'b1, 1'b0, 32'h3000_0000, 32'h0);
        check("acc_claimed", acc_claimed, 1'b0);
        do_acc(1'b1, 1'b0, 32'h2FFF_FFF0, 32'h0000_0042);
        check("mem", mem, 32'h0000_0042);
    endtask : test_translate

    task automatic test_rmw;
        reg_wr(OFF_SC_CTL, {30'h0, SEL_RMW});
        reg_wr(OFF_SC_MASK, 32'h0000_FFFF);
        reg_wr(OFF_SC_CMP, 32'h0000_1234);
        reg_wr(OFF_SC_SWP, 32'h9999_ABCD);
        slow <= 1'b1;
        preload(32'h5555_1234);
        do_acc(1'b0, 1'b0, SPC + 32'h3, 32'h0);
        check("kinds", kinds, 4'hC);
        check("mem", mem, 32'h5555_ABCD);
        check("acc_rdata", acc_rdata, 32'h5555_1234);
        reg_rd(OFF_STATUS, 32'h0000_0004);
        check("vme.addr", seen_addr, 32'h1345_678B);
        check("ack64_permit", ack64_permit, 1'b0);
        preload(32'h5555_1230);
        do_acc(1'b0, 1'b0, SPC, 32'h0);
        check("kinds", kinds, 4'h4);
        check("mem", mem, 32'h5555_1230);
        do_acc(1'b1, 1'b0, SPC, 32'h0BAD_F00D);
        check("mem", mem, 32'h0BAD_F00D);
        do_acc(1'b0, 1'b1, SPC, 32'h0);
        check("kinds", kinds, 4'h0);
        reg_wr(OFF_SC_CTL, 32'h0000_0005);
        preload(32'hFFFF_1234);
        do_acc(1'b0, 1'b1, SPC, 32'h0);
        check("mem", mem, 32'hFFFF_ABCD);
        slow <= 1'b0;
    endtask : test_rmw

    task automatic test_addr_only;
        reg_wr(OFF_SC_CTL, {30'h0, SEL_ADDR});
        preload(32'h0000_0077);
        for (int k = 0; k < 4; k++) begin
            do_acc(k[0], k[1], SPC, 32'h1111_1111);
            check("kinds", kinds, 4'h2);
            check("mem", mem, 32'h0000_0077);
        end
        do_acc(1'b0, 1'b0, SPC ^ 32'h4, 32'h0);
        check("kinds", kinds, 4'h1);
        reg_wr(OFF_SC_CTL, 32'h0000_0003);
        do_acc(1'b0, 1'b0, SPC, 32'h0);
        check("kinds", kinds, 4'h1);
    endtask : test_addr_only

    // window codes in turn; code 1 gets a second access to restart the count
    task automatic test_window;
        int n;
        int t;
        for (int c = 0; c < 8; c++) begin
            reg_wr(OFF_IMG3_CTL, 32'h0);
            reg_wr(OFF_MISC, {4'hF, 1'b0, c[2:0], 24'h0});
            reg_wr(OFF_IMG3_CTL, 32'h8000_0000);
            do_acc(1'b0, 1'b0, 32'h1000_0000, 32'h0);
            t = (c == 0 || c == 7) ? 0 : 16 << (c - 1);
            if (c == 1) begin
                repeat (100) @(posedge sys_clk);
                do_acc(1'b0, 1'b0, 32'h1000_0000, 32'h0);
            end
            own_time(n);
            check("vme_own span", (n + 16 >= t * 12) && (n <= t * 12 + 8), 1'b1);
        end
        // posted memory write holds nothing; io image ignores the posted bit
        reg_wr(OFF_IMG3_CTL, 32'h0);
        reg_wr(OFF_MISC, 32'hF100_0000);
        reg_wr(OFF_IMG3_CTL, 32'hC000_0000);
        do_acc(1'b1, 1'b0, 32'h1000_0000, 32'h0);
        own_time(n);
        check("vme_own posted", n, 32'h0);
        reg_wr(OFF_IMG3_CTL, 32'hC000_0001);
        do_acc(1'b1, 1'b1, 32'h1000_0000, 32'h0);
        own_time(n);
        check("vme_own io", (n + 16 >= 192) && (n <= 200), 1'b1);
    endtask : test_window

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        test_regs();
        test_translate();
        test_rmw();
        test_addr_only();
        test_window();
        end_of_test();
    end
endmodule : psc_slave_bench
`default_nettype wire

// [psc_vme_model.sv]
// behavioural vme slave that answers the bridge from one storage word
`timescale 1ns/1ns
`default_nettype none
module psc_vme_model (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  slow,
    input  wire logic                  load,
    input  wire logic [31:0]           load_data,
    input  wire psc_pkg::psc_vme_req_s vme,
    output logic                       vme_ack,
    output logic      [31:0]           vme_rdata,
    output logic      [31:0]           mem
);
    import psc_pkg::*;
    logic [2:0] wait_cnt;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_cnt  <= 3'h0;
            vme_ack   <= 1'b0;
            vme_rdata <= 32'h0;
            mem       <= 32'h0;
        end else begin
            vme_ack   <= 1'b0;
            // data lines invert every cycle outside an answer, so the old word comes back every other cycle
            vme_rdata <= ~vme_rdata;
            if (load) begin
                mem <= load_data;
            end
            if (vme.req && !vme_ack) begin
                if (wait_cnt >= (slow ? 3'h4 : 3'h0)) begin
                    wait_cnt <= 3'h0;
                    vme_ack  <= 1'b1;
                    if (vme.kind != VME_ADDR_ONLY && vme.write) begin
                        mem <= vme.wdata;
                    end else if (vme.kind != VME_ADDR_ONLY) begin
                        vme_rdata <= mem;
                    end
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
endmodule : psc_vme_model
`default_nettype wire
